// File: src/sdc_pkg.sv
// Purpose: constants and types shared by the synchronous dram command-side logic
// Assumes: 25 MHz system clock, x16 data path with two byte masks
// Notes: nanosecond minimums are turned into whole cycles by rounding up
package sdc_pkg;
    // clock and analog-derived timing
    localparam int CLK_PERIOD_PS = 40000;
    localparam int WR_EXTRA_PS = 7500;
    localparam int PRECHARGE_PERIOD_PS = 20000;
    // write recovery is one clock plus a time; precharge period follows it
    localparam int WR_CYC = 1 + (WR_EXTRA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RP_CYC = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // fixed clock counts, independent of the clock period
    localparam int COLUMN_CMD_GAP = 1;
    localparam int CLOCK_DISABLE_LATENCY = 1;
    localparam int CLOCK_RESUME_LATENCY = 1;
    localparam int WRITE_MASK_LATENCY = 0;
    localparam int READ_MASK_TRISTATE_LATENCY = 2;
    localparam int WRITE_DATA_DELAY = 0;

    // widths
    localparam int DQ_W = 16;
    localparam int DQM_W = 2;
    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int COL_W = 3;
    localparam int IDX_W = BA_W + COL_W;
    localparam int MEM_DEPTH = 32;
    localparam int TAP_W = IDX_W + DQ_W;
    localparam int TAP_DEPTH = 32;
    localparam int RPIPE_D = 3;

    // command codes as {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_LMR = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // address fields
    localparam int AP_BIT = 10;
    localparam int BL_LSB = 0;
    localparam int CL_LSB = 4;
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [1:0] BL_RST = 2'h0;
    localparam logic [3:0] AP_CNT_W = 4'(WR_CYC + RP_CYC);
    localparam logic [3:0] AP_CNT_R = 4'(RP_CYC);

    typedef enum logic [2:0] {
        BST_IDLE = 3'b001,
        BST_READ = 3'b010,
        BST_WRITE = 3'b100
    } sdc_bst_e;

    typedef enum logic [3:0] {
        PWR_RUN = 4'b0001,
        PWR_SUSP = 4'b0010,
        PWR_DOWN = 4'b0100,
        PWR_SELF = 4'b1000
    } sdc_pwr_e;
endpackage : sdc_pkg

// File: src/sdc_fifo.sv
// Purpose: synchronous valid/ready fifo in flip-flops
// Assumes: single clock, synchronous active-high reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
module sdc_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [PW:0] wp_r;
    logic [PW:0] rp_r;
    logic push;
    logic pop;

    assign in_ready = (wp_r - rp_r) != (PW+1)'(D);
    assign out_valid = wp_r != rp_r;
    assign out_data = mem_r[rp_r[PW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r <= '0;
        end else if (push) begin
            wp_r <= wp_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rp_r <= '0;
        end else if (pop) begin
            rp_r <= rp_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r[PW-1:0]] <= in_data;
        end
    end
endmodule : sdc_fifo

// File: src/sdc_core.sv
// Purpose: command decode, burst, masking and clock-gating of a synchronous dram
// Assumes: pins sampled on clk; controller keeps its own spacing
// Notes: small flop array stands in for the cell array; writes are mirrored to a tap fifo
// Behaviour
// - column commands accepted every cycle
// - cke low suspends clock one cycle later
// - cke high resumes clock one cycle later
// - write byte mask blocks same-cycle data
// - write mask latency is zero cycles
// - read byte mask tristates two cycles later
// - first write data taken with command
// - precharge ends read after read latency
// - auto precharge starts after write recovery
// - fixed cycle counts independent of period
// - chip select high means no operation
`timescale 1ns/1ps
module sdc_core (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sdc_pkg::BA_W-1:0] ba,
    input wire logic [sdc_pkg::ADDR_W-1:0] addr,
    input wire logic [sdc_pkg::DQM_W-1:0] dqm,
    // data pins
    input wire logic [sdc_pkg::DQ_W-1:0] dq_i,
    output logic [sdc_pkg::DQ_W-1:0] dq_o,
    output logic [sdc_pkg::DQM_W-1:0] dq_oe,
    // status
    output logic power_down,
    output logic self_refresh,
    output logic clk_suspended,
    output logic [3:0] bank_open,
    // write tap
    output logic tap_valid,
    input wire logic tap_ready,
    output logic [sdc_pkg::TAP_W-1:0] tap_data,
    output logic tap_room,
    output logic tap_lost
);
    import sdc_pkg::*;

    localparam int AP_W_CHK = WR_CYC + RP_CYC + 1;

    logic cke_r;
    logic act;
    logic [2:0] cmd;
    logic col_cmd;
    logic stop_cmd;
    logic cont;
    logic wr_beat;
    logic rd_beat;
    logic last_beat;
    logic ap_go;
    logic [3:0] bl;
    logic [IDX_W-1:0] beat_idx;
    logic [DQ_W-1:0] wr_merged;
    sdc_bst_e bst_r;
    sdc_pwr_e pwr_r;
    logic [COL_W-1:0] col_r;
    logic [BA_W-1:0] bnk_r;
    logic [3:0] beat_r;
    logic ap_r;
    logic [2:0] cl_r;
    logic [1:0] bl_code_r;
    logic [3:0] bank_open_r;
    logic [3:0] ap_cnt_r;
    logic [BA_W-1:0] ap_bnk_r;
    logic [DQ_W-1:0] mem_r [MEM_DEPTH];
    logic [RPIPE_D-1:0] rp_v_r;
    logic [DQ_W-1:0] rp_d_r [RPIPE_D];
    logic [DQM_W-1:0] dm1_r;
    logic [DQM_W-1:0] dm2_r;
    logic tap_push;
    logic tap_lost_r;

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    // internal clock runs only if cke was high at the previous edge
    assign act = cke_r;
    assign cmd = cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
    assign col_cmd = act && (cmd == CMD_RD || cmd == CMD_WR);
    assign stop_cmd = act && (cmd == CMD_PRE || cmd == CMD_BST);
    assign cont = act && bst_r != BST_IDLE && !col_cmd && !stop_cmd;
    // a new column command simply restarts the burst
    assign wr_beat = (col_cmd && cmd == CMD_WR) || (cont && bst_r == BST_WRITE);
    assign rd_beat = (col_cmd && cmd == CMD_RD) || (cont && bst_r == BST_READ);
    assign bl = 4'h1 << bl_code_r;
    assign beat_idx = col_cmd ? {ba, addr[COL_W-1:0]} : {bnk_r, col_r};
    assign last_beat = col_cmd ? (bl == 4'h1) : (beat_r == 4'h1);
    assign ap_go = (wr_beat || rd_beat) && last_beat && (col_cmd ? addr[AP_BIT] : ap_r);

    always_ff @(posedge clk) begin
        if (srst) begin
            cke_r <= 1'b0;
        end else begin
            cke_r <= cke;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cl_r <= CL_RST;
            bl_code_r <= BL_RST;
        end else if (act && cmd == CMD_LMR) begin
            // only latencies 2 and 3 and bursts up to 8 are kept
            if (addr[CL_LSB+2:CL_LSB] == 3'h2 || addr[CL_LSB+2:CL_LSB] == 3'h3) begin
                cl_r <= addr[CL_LSB+2:CL_LSB];
            end
            if (addr[BL_LSB+2] == 1'b0) begin
                bl_code_r <= addr[BL_LSB+1:BL_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // burst sequencing

    always_ff @(posedge clk) begin
        if (srst) begin
            bst_r <= BST_IDLE;
            col_r <= '0;
            bnk_r <= '0;
            beat_r <= '0;
            ap_r <= 1'b0;
        end else if (col_cmd) begin
            bst_r <= (bl == 4'h1) ? BST_IDLE : ((cmd == CMD_RD) ? BST_READ : BST_WRITE);
            bnk_r <= ba;
            ap_r <= addr[AP_BIT];
            beat_r <= bl - 4'h1;
            col_r <= (addr[COL_W-1:0] & ~3'(bl - 4'h1)) | ((addr[COL_W-1:0] + 3'h1) & 3'(bl - 4'h1));
        end else if (stop_cmd) begin
            // stopping issue here leaves only the words already in flight
            bst_r <= BST_IDLE;
        end else if (cont) begin
            beat_r <= beat_r - 4'h1;
            col_r <= (col_r & ~3'(bl - 4'h1)) | ((col_r + 3'h1) & 3'(bl - 4'h1));
            if (beat_r == 4'h1) begin
                bst_r <= BST_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // banks and auto precharge

    // recovery and precharge are internal times, so this timer runs even while suspended
    always_ff @(posedge clk) begin
        if (srst) begin
            ap_cnt_r <= '0;
            ap_bnk_r <= '0;
        end else if (act && ap_go) begin
            ap_cnt_r <= wr_beat ? AP_CNT_W : AP_CNT_R;
            ap_bnk_r <= col_cmd ? ba : bnk_r;
        end else if (ap_cnt_r != 4'h0) begin
            ap_cnt_r <= ap_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bank_open_r <= '0;
        end else begin
            if (ap_cnt_r == 4'h1) begin
                bank_open_r[ap_bnk_r] <= 1'b0;
            end
            if (act && cmd == CMD_ACT) begin
                bank_open_r[ba] <= 1'b1;
            end else if (act && cmd == CMD_PRE) begin
                if (addr[AP_BIT]) begin
                    bank_open_r <= '0;
                end else begin
                    bank_open_r[ba] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write path

    // mask acts on the data of the same edge
    always_comb begin
        wr_merged = mem_r[beat_idx];
        for (int i = 0; i < DQM_W; i++) begin
            if (!dqm[i]) begin
                wr_merged[i*8 +: 8] = dq_i[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (wr_beat) begin
            mem_r[beat_idx] <= wr_merged;
        end
    end

    // the tap never stalls the pins; a word that finds it full is lost and flagged
    assign tap_push = wr_beat && dqm != {DQM_W{1'b1}};

    always_ff @(posedge clk) begin
        if (srst) begin
            tap_lost_r <= 1'b0;
        end else if (tap_push && !tap_room) begin
            tap_lost_r <= 1'b1;
        end
    end

    sdc_fifo #(
        .W(TAP_W),
        .D(TAP_DEPTH)
    ) u_tap (
        .clk(clk),
        .srst(srst),
        .in_valid(tap_push),
        .in_ready(tap_room),
        .in_data({beat_idx, wr_merged}),
        .out_valid(tap_valid),
        .out_ready(tap_ready),
        .out_data(tap_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read path

    // pipeline and mask history freeze with the internal clock
    always_ff @(posedge clk) begin
        if (srst) begin
            rp_v_r <= '0;
            dm1_r <= '0;
            dm2_r <= '0;
        end else if (act) begin
            rp_v_r <= {rp_v_r[RPIPE_D-2:0], rd_beat};
            dm1_r <= dqm;
            dm2_r <= dm1_r;
        end
    end

    always_ff @(posedge clk) begin
        if (act) begin
            rp_d_r[0] <= mem_r[beat_idx];
            for (int i = 1; i < RPIPE_D; i++) begin
                rp_d_r[i] <= rp_d_r[i-1];
            end
        end
    end

    // stage cl-1 is on the pins and sampled by the controller at edge cl
    always_comb begin
        dq_o = (cl_r == 3'h3) ? rp_d_r[2] : rp_d_r[1];
        for (int i = 0; i < DQM_W; i++) begin
            dq_oe[i] = ((cl_r == 3'h3) ? rp_v_r[2] : rp_v_r[1]) && !dm2_r[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power state

    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_r <= PWR_RUN;
        end else if (cke_r && !cke) begin
            if (cmd == CMD_REF) begin
                pwr_r <= PWR_SELF;
            end else if (bst_r == BST_IDLE && rp_v_r == '0) begin
                pwr_r <= PWR_DOWN;
            end else begin
                pwr_r <= PWR_SUSP;
            end
        end else if (!cke_r && cke) begin
            pwr_r <= PWR_RUN;
        end
    end

    always_comb begin
        power_down = 1'b0;
        self_refresh = 1'b0;
        clk_suspended = 1'b0;
        case (pwr_r)
            PWR_RUN: begin
            end
            PWR_SUSP: clk_suspended = 1'b1;
            PWR_DOWN: power_down = 1'b1;
            PWR_SELF: self_refresh = 1'b1;
            default: clk_suspended = 1'b1;
        endcase
    end

    assign bank_open = bank_open_r;
    assign tap_lost = tap_lost_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic chk_we_r;
    logic [IDX_W-1:0] chk_idx_r;
    logic [DQ_W-1:0] chk_dat_r;
    logic [DQ_W-1:0] chk_old_r;
    logic [DQM_W-1:0] chk_dm_r;

    always_ff @(posedge clk) begin
        chk_we_r <= wr_beat && !srst;
        chk_idx_r <= beat_idx;
        chk_dat_r <= dq_i;
        chk_old_r <= mem_r[beat_idx];
        chk_dm_r <= dqm;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_resume;
        (!cke_r && cke && bst_r == BST_READ) ##1 (cmd == CMD_NOP);
    endsequence
    sequence s_pre3;
        (stop_cmd && cmd == CMD_PRE && cl_r == 3'h3) ##1 (act && !rd_beat)[*2];
    endsequence
    sequence s_pre2;
        (stop_cmd && cmd == CMD_PRE && cl_r == 3'h2) ##1 (act && !rd_beat);
    endsequence

    property p_col_b2b;
        (col_cmd && cmd == CMD_RD) ##1 (col_cmd && cmd == CMD_RD) |=> rp_v_r[1:0] == 2'h3;
    endproperty
    a_col_b2b: assert property (p_col_b2b) else $error("back to back read lost a word");

    property p_suspend;
        (!cke && bst_r != BST_IDLE) |-> ##2 ($stable(beat_r) && $stable(col_r));
    endproperty
    a_suspend: assert property (p_suspend) else $error("burst advanced while suspended");

    property p_resume;
        s_resume |=> rp_v_r[0];
    endproperty
    a_resume: assert property (p_resume) else $error("burst did not resume");

    property p_wr_mask;
        chk_we_r && chk_dm_r[1] |-> mem_r[chk_idx_r][15:8] == chk_old_r[15:8];
    endproperty
    a_wr_mask: assert property (p_wr_mask) else $error("masked byte was written");

    property p_wr_take;
        chk_we_r && !chk_dm_r[0] |-> mem_r[chk_idx_r][7:0] == chk_dat_r[7:0];
    endproperty
    a_wr_take: assert property (p_wr_take) else $error("write data not captured");

    property p_rd_mask;
        (act && dqm[0]) ##1 act |=> !dq_oe[0];
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("read mask did not tristate");

    property p_pre3;
        s_pre3 |=> dq_oe == '0;
    endproperty
    a_pre3: assert property (p_pre3) else $error("outputs driven after precharge");

    property p_pre2;
        s_pre2 |=> dq_oe == '0;
    endproperty
    a_pre2: assert property (p_pre2) else $error("outputs driven after precharge");

    property p_ap_wr;
        (act && ap_go && wr_beat && !(cmd == CMD_ACT)) ##1 (ap_cnt_r != 4'h0 && !act || cmd != CMD_ACT)[*2]
            |-> ##AP_W_CHK !bank_open_r[ap_bnk_r];
    endproperty
    a_ap_wr: assert property (p_ap_wr) else $error("auto precharge bank still open");

    property p_desel;
        (cs_n && act && bst_r == BST_IDLE && ap_cnt_r == 4'h0) |=>
            (bst_r == BST_IDLE && $stable(bank_open_r));
    endproperty
    a_desel: assert property (p_desel) else $error("deselected command executed");
endmodule : sdc_core

// File: verif/sdc_ctl_model.sv
// Purpose: controller-side model driving the dram command and data pins
// Assumes: pins change just after a rising edge and stand for one full cycle
// Notes: spacing between commands is kept by the sequence that calls step
`timescale 1ns/1ps
module sdc_ctl_model (
    // clock
    input wire logic clk,
    // command pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [sdc_pkg::BA_W-1:0] ba,
    output logic [sdc_pkg::ADDR_W-1:0] addr,
    output logic [sdc_pkg::DQM_W-1:0] dqm,
    // data pins
    output logic [sdc_pkg::DQ_W-1:0] dq_i
);
    import sdc_pkg::*;
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = CMD_NOP;
        ba = '0;
        addr = '0;
        dqm = '0;
        dq_i = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one command per edge on a free-running clock; gaps are whole nop cycles
    // callers put fresh noise on dq_i off the write beats, never the last word
    task automatic step(input logic k, input logic s_n, input logic [2:0] c,
                        input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a,
                        input logic [DQM_W-1:0] m, input logic [DQ_W-1:0] d);
        @(posedge clk);
        cke <= k;
        cs_n <= s_n;
        {ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        dqm <= m;
        dq_i <= d;
    endtask : step
endmodule : sdc_ctl_model

// File: verif/sdc_command_cycle_timing_tb_top.sv
// Purpose: self-checking bench for the dram command core
// Assumes: 25 MHz clock, controller model on the pins, cycle-level reference model
// Notes: edge ids count rising edges; results are compared at the falling edge
`timescale 1ns/1ps
module sdc_command_cycle_timing_tb_top;
    import sdc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic tap_ready = 1'b0;
    logic cke, cs_n, ras_n, cas_n, we_n;
    logic power_down, self_refresh, clk_suspended, tap_valid, tap_room, tap_lost;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQM_W-1:0] dqm, dq_oe, eo;
    logic [DQ_W-1:0] dq_i, dq_o;
    logic [3:0] bank_open;
    logic [TAP_W-1:0] tap_data;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 63370;
    int cyc = 0;
    int cl = 3;
    int bl = 1;
    int wr_left = 0;
    int wr_b, wr_a, wr_i;
    bit k_last = 1'b0;
    bit chk_on = 1'b0;
    bit rdy_en = 1'b1;
    logic [DQ_W-1:0] mem [MEM_DEPTH];
    logic [DQ_W-1:0] exp_d [int];
    logic [DQM_W-1:0] mask_at [int];
    logic [TAP_W-1:0] tap_q [$];

    always #20 clk = ~clk;

    sdc_ctl_model i_ctl (.clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dqm, .dq_i);
    sdc_core i_dut (.clk, .srst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dqm, .dq_i,
        .dq_o, .dq_oe, .power_down, .self_refresh, .clk_suspended, .bank_open, .tap_valid,
        .tap_ready, .tap_data, .tap_room, .tap_lost);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic results();
        $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    function automatic logic [DQM_W-1:0] rm();
        return DQM_W'($random(seed));
    endfunction : rm

    function automatic logic [DQ_W-1:0] rd();
        return DQ_W'($random(seed));
    endfunction : rd

    // column wraps inside the burst; upper column bits alias onto the small array
    function automatic logic [IDX_W-1:0] bidx(input int b, input int a, input int i);
        int col;
        col = (a & ~(bl - 1)) | ((a + i) & (bl - 1));
        return IDX_W'((b << COL_W) | (col & 7));
    endfunction : bidx

    // drive one edge and advance the reference model to it
    task automatic op(input bit k, input bit s_n, input logic [2:0] c, input int b, input int a,
                      input logic [DQM_W-1:0] m, input logic [DQ_W-1:0] d);
        int e;
        int i;
        logic [IDX_W-1:0] ix;
        logic [DQ_W-1:0] w;
        i_ctl.step(k, s_n, c, BA_W'(b), ADDR_W'(a), m, d);
        tap_ready <= rdy_en & 1'($random(seed));
        e = cyc + 1;
        mask_at[e] = m;
        if (k_last && !s_n && c != CMD_NOP && c != CMD_ACT && c != CMD_REF) begin
            if (c == CMD_LMR) begin
                if (((a >> 4) & 7) inside {2, 3}) cl = (a >> 4) & 7;
                if ((a & 7) < 4) bl = 1 << (a & 7);
            end else begin
                wr_left = 0;
                for (i = e + cl - 1; i < e + 16; i++) exp_d.delete(i);
            end
            if (c == CMD_RD) for (i = 0; i < bl; i++) exp_d[e + cl - 1 + i] = mem[bidx(b, a, i)];
            if (c == CMD_WR) begin
                wr_left = bl;
                wr_b = b;
                wr_a = a;
                wr_i = 0;
            end
        end
        if (k_last && wr_left > 0) begin // first beat with the command
            ix = bidx(wr_b, wr_a, wr_i);
            w = mem[ix];
            for (i = 0; i < DQM_W; i++) if (!m[i]) w[i*8 +: 8] = d[i*8 +: 8];
            mem[ix] = w;
            // a fully masked beat carries nothing and is not mirrored to the tap
            if (m != '1 && tap_q.size() < TAP_DEPTH) tap_q.push_back({ix, w});
            wr_i++;
            wr_left--;
        end
        k_last = k;
    endtask : op

    task automatic nops(input int n);
        repeat (n) op(1, 0, CMD_NOP, 0, 0, rm(), rd());
    endtask : nops

    task automatic fill8(input int b);
        for (int i = 0; i < 8; i++) op(1, 0, i ? CMD_NOP : CMD_WR, b, 0, '0, rd());
        nops(1); // next column command two cycles after the last data
    endtask : fill8

    task automatic act_all();
        for (int i = 0; i < 4; i++) op(1, 0, CMD_ACT, i, $random(seed), rm(), rd());
        nops(1);
        #1 check(bank_open === 4'hF, "banks opened");
    endtask : act_all

    task automatic wr_round();
        for (int i = 0; i < 4; i++) op(1, 0, CMD_WR, $random(seed) & 3, $random(seed) & 'h3FF, rm(), rd()); // back to back
        nops(bl); // trailing beats, then a free cycle
    endtask : wr_round

    task automatic rd_round();
        for (int i = 0; i < 4; i++) op(1, 0, CMD_RD, $random(seed) & 3, $random(seed) & 'h3FF, rm(), rd()); // back to back
        op(1, 0, CMD_PRE, 0, 1 << AP_BIT, rm(), rd()); // cuts the last burst
        nops(cl + 2);
        #1 check(bank_open === 4'h0, "banks closed by precharge");
        act_all();
    endtask : rd_round

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (chk_on) begin
            eo = exp_d.exists(cyc) ? ~mask_at[cyc - 1] : '0;
            check(dq_oe === eo, "read output enable"); // mask and precharge tristate
            for (int j = 0; j < DQM_W; j++)
                if (eo[j]) check(dq_o[j*8 +: 8] === exp_d[cyc][j*8 +: 8], "read data");
        end
        if (tap_valid === 1'b1 && tap_ready === 1'b1) begin
            if (tap_q.size() > 0) check(tap_data === tap_q.pop_front(), "tap word");
            else check(1'b0, "tap word not expected");
        end
        cyc = cyc + 1;
    end

    initial begin
        #400000;
        n_errors++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        k_last = 1'b0;
        chk_on = 1'b1;
        nops(1);
        #1 check({tap_room, bank_open, power_down, self_refresh, clk_suspended, tap_valid,
                  tap_lost} === 10'h200, "reset state");
        nops(2500); // power-up pause
        repeat (2) begin
            op(1, 0, CMD_REF, 0, 0, rm(), rd());
            nops(2); // refresh period
        end
        op(1, 0, CMD_LMR, 0, 'h23, rm(), rd());
        nops(2); // mode load gap
        act_all();
        for (int b = 0; b < 4; b++) fill8(b);
        for (int c = 2; c <= 3; c++) for (int k = 0; k < 4; k++) begin
            op(1, 1, CMD_WR, 0, 0, '0, rd()); // deselected write is ignored
            op(1, 0, CMD_LMR, 0, (c << 4) | k, rm(), rd());
            nops(2);
            wr_round();
            rd_round();
        end
        op(1, 0, CMD_LMR, 0, 'h54, rm(), rd()); // invalid fields keep latency 3, burst 8
        nops(2);
        wr_round();
        rd_round();
        // auto-precharge write, burst of one
        op(1, 0, CMD_LMR, 0, 'h30, rm(), rd());
        nops(2);
        op(1, 0, CMD_WR, 1, (1 << AP_BIT) | 5, '0, rd());
        nops(WR_CYC + RP_CYC);
        #1 check(bank_open[1] === 1'b1, "bank open during recovery");
        nops(1);
        #1 check(bank_open[1] === 1'b0, "auto precharge done");
        nops(2); // activate gap
        op(1, 0, CMD_ACT, 1, 0, rm(), rd());
        nops(2);
        // power-down from idle
        op(0, 0, CMD_NOP, 0, 0, rm(), rd());
        op(0, 0, CMD_WR, 0, 0, rm(), rd()); // ignored while clock is off
        #1 check(power_down === 1'b1, "power-down entry");
        op(1, 0, CMD_NOP, 0, 0, rm(), rd());
        #1 check(power_down === 1'b1, "power-down held");
        nops(1);
        #1 check(power_down === 1'b0, "power-down exit");
        // self refresh
        op(0, 0, CMD_REF, 0, 0, rm(), rd());
        op(0, 0, CMD_NOP, 0, 0, rm(), rd());
        #1 check(self_refresh === 1'b1, "self refresh entry");
        op(1, 0, CMD_NOP, 0, 0, rm(), rd());
        nops(1);
        #1 check(self_refresh === 1'b0, "self refresh exit");
        nops(2); // exit interval
        // clock suspend in a read burst; data held, so comparisons pause
        op(1, 0, CMD_LMR, 0, 'h33, rm(), rd());
        nops(2);
        chk_on = 1'b0;
        op(1, 0, CMD_RD, 0, 0, rm(), rd());
        nops(1);
        op(0, 0, CMD_NOP, 0, 0, rm(), rd());
        op(1, 0, CMD_NOP, 0, 0, rm(), rd());
        #1 check(clk_suspended === 1'b1, "clock suspend entry");
        nops(1);
        #1 check(clk_suspended === 1'b0, "clock suspend exit");
        nops(12);
        op(1, 0, CMD_PRE, 0, 1 << AP_BIT, rm(), rd());
        nops(4);
        exp_d.delete();
        chk_on = 1'b1;
        act_all();
        // fill the tap fifo past full with the drain stalled, then drain it
        nops(40);
        rdy_en = 1'b0;
        nops(1);
        for (int i = 0; i < 5; i++) fill8($random(seed) & 3);
        #1 check(tap_room === 1'b0 && tap_lost === 1'b1, "tap fifo full and overflow flagged");
        rdy_en = 1'b1;
        nops(150);
        #1 check(tap_valid === 1'b0 && tap_room === 1'b1 && tap_q.size() == 0, "tap fifo drained");
        check(tap_lost === 1'b1, "overflow flag sticky");
        // burst stop on a write and on a read, latency 3, burst 8
        op(1, 0, CMD_WR, 2, 3, rm(), rd());
        nops(1);
        op(1, 0, CMD_BST, 0, 0, rm(), rd()); // stop a cycle after the last kept word
        op(1, 0, CMD_RD, 2, 3, rm(), rd());
        op(1, 0, CMD_BST, 0, 0, rm(), rd()); // read cut after its first word
        nops(cl + 2);
        rd_round();
        nops(10);
        results();
    end
endmodule : sdc_command_cycle_timing_tb_top
